/* hdl/emi_regs.svh */
`ifndef EMI_REGS_SVH
`define EMI_REGS_SVH

// register indices; byte address is four times the index
`define EMI_IDX_CONFIG     8'hB2
`define EMI_IDX_PAGE       8'hAA
`define EMI_IDX_STATUS     8'hC0
`define EMI_ADDR_CONFIG    12'h2C8
`define EMI_ADDR_PAGE      12'h2A8
`define EMI_ADDR_STATUS    12'h300

// ext_mem_config fields
`define EMI_CFG_RST        5'h03
`define EMI_CFG_BUS_BIT    4
`define EMI_CFG_MODE_HI    3
`define EMI_CFG_MODE_LO    2
`define EMI_CFG_ALE_HI     1
`define EMI_CFG_ALE_LO     0
`define EMI_PAGE_RST       8'h00

// status fields
`define EMI_STAT_BUSY      0
`define EMI_STAT_OFF       1

// memory map
`define EMI_ONCHIP_AW      12
`define EMI_MODE_INT       2'h0
`define EMI_MODE_SPLIT_NB  2'h1
`define EMI_MODE_SPLIT_BS  2'h2
`define EMI_MODE_EXT       2'h3

// read/write strobe length minus one, covers the pin synchroniser
`define EMI_STRB_CNT       2'h2

`endif

/* hdl/emi_pkg.sv */
package emi_pkg;

	typedef enum logic [2:0] {
		EMI_IDLE,
		EMI_ONCHIP,
		EMI_ALE_HI,
		EMI_ALE_LO,
		EMI_STROBE,
		EMI_HOLD
	} emi_state_t;

	typedef logic [1:0] emi_mode_t;

endpackage

/* hdl/emi_onchip_ram.sv */
`timescale 1ns/1ps
module emi_onchip_ram #(
	parameter int AW = 12
) (
	// clock
	input  wire logic          clk_sys,
	// access
	input  wire logic          en,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata
);

	logic [7:0] mem [0:(1<<AW)-1];

	// no reset: ram contents are undefined after power-up
	always_ff @(posedge clk_sys) begin
		if (en) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end

endmodule

/* hdl/emi_ctrl.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "emi_regs.svh"
module emi_ctrl
	import emi_pkg::*;
#(
	parameter int ONCHIP_AW = `EMI_ONCHIP_AW
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// cpu ext_data_move requests
	input  wire logic        cpu_req,
	input  wire logic        cpu_we,
	input  wire logic        cpu_is8,
	input  wire logic [15:0] cpu_dptr,
	input  wire logic [7:0]  indirect_pointer_reg,
	input  wire logic [7:0]  cpu_wdata,
	output logic             cpu_ack,
	output logic      [7:0]  cpu_rdata,
	// external pins
	input  wire logic [7:0]  ad_i,
	output logic      [7:0]  ad_o,
	output logic             ad_oe,
	output logic      [7:0]  addr_lo_o,
	output logic             addr_lo_oe,
	output logic      [7:0]  addr_hi_o,
	output logic             addr_hi_oe,
	output logic             ale_o,
	output logic             rd_n_o,
	output logic             wr_n_o,
	output logic             bus_own_o
);

	////////////////////////////////////////////////////////////////
	typedef struct packed {
		// access sequencer and software registers
		emi_state_t  state;
		logic [4:0]  cfg;
		logic [7:0]  page;
		logic [1:0]  cnt;
		logic [1:0]  alw;
		logic        we;
		logic [7:0]  wdata;
		logic        last_off;

		// shared data pins, two flops deep
		logic [7:0]  sync1;
		logic [7:0]  sync2;

		// answers to the bus and the cpu
		logic [31:0] prdata;
		logic        ack;
		logic [7:0]  rdata;

		// pin drivers
		logic [7:0]  ad_o;
		logic        ad_oe;
		logic [7:0]  lo_o;
		logic        lo_oe;
		logic [7:0]  hi_o;
		logic        hi_oe;
		logic        ale;
		logic        rd_n;
		logic        wr_n;
		logic        own;
	} emi_ctrl_state_t;

	emi_ctrl_state_t s_q;
	emi_ctrl_state_t s_d;

	////////////////////////////////////////////////////////////////
	// decode of the current access
	logic                 bus_sep;
	emi_mode_t            mode;
	logic [1:0]           ale_w;
	logic [15:0]          eff_addr;
	logic                 above;
	logic                 go_off;
	logic                 drive_hi;
	logic                 accept;
	logic                 ram_en;
	logic [7:0]           ram_rdata;
	logic                 apb_setup;
	logic                 apb_wr;
	logic                 hit_cfg;
	logic                 hit_page;
	logic                 hit_stat;
	logic [31:0]          rd_mux;

	assign bus_sep = s_q.cfg[`EMI_CFG_BUS_BIT];
	assign mode    = s_q.cfg[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO];
	assign ale_w   = s_q.cfg[`EMI_CFG_ALE_HI:`EMI_CFG_ALE_LO];

	// page gives the high byte, pointer the low byte on 8-bit moves
	assign eff_addr = cpu_is8 ? {s_q.page, indirect_pointer_reg}
		: cpu_dptr;

	// anything at or past the on-chip size lies off-chip in split modes
	assign above = |eff_addr[15:ONCHIP_AW];

	always_comb begin
		unique case (mode)
			`EMI_MODE_INT: begin
				go_off = 1'b0;
			end
			`EMI_MODE_SPLIT_NB: begin
				go_off = above;
			end
			`EMI_MODE_SPLIT_BS: begin
				go_off = above;
			end
			`EMI_MODE_EXT: begin
				go_off = 1'b1;
			end
		endcase
	end

	// 8-bit moves leave the high byte to the port latches except in bank mode
	always_comb begin
		unique case (mode)
			`EMI_MODE_SPLIT_BS: begin
				drive_hi = 1'b1;
			end
			`EMI_MODE_INT, `EMI_MODE_SPLIT_NB, `EMI_MODE_EXT: begin
				drive_hi = !cpu_is8;
			end
		endcase
	end

	// ack_q blocks a request that is still held in the ack cycle
	assign accept = cpu_req && (s_q.state == EMI_IDLE) && !s_q.ack;
	assign ram_en = accept && !go_off;

	////////////////////////////////////////////////////////////////
	// on-chip ram, addresses wrap on the on-chip size
	emi_onchip_ram #(
		.AW(ONCHIP_AW)
	) u_ram (
		.clk_sys (clk_sys),
		.en      (ram_en),
		.we      (cpu_we),
		.addr    (eff_addr[ONCHIP_AW-1:0]),
		.wdata   (cpu_wdata),
		.rdata   (ram_rdata)
	);

	////////////////////////////////////////////////////////////////
	// apb decode; zero wait states, read data captured in setup
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign hit_cfg   = (paddr == `EMI_ADDR_CONFIG);
	assign hit_page  = (paddr == `EMI_ADDR_PAGE);
	assign hit_stat  = (paddr == `EMI_ADDR_STATUS);

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_cfg) begin
			rd_mux[`EMI_CFG_BUS_BIT:0] = s_q.cfg;
		end else if (hit_page) begin
			rd_mux[7:0] = s_q.page;
		end else if (hit_stat) begin
			rd_mux[`EMI_STAT_BUSY] = (s_q.state != EMI_IDLE);
			rd_mux[`EMI_STAT_OFF]  = s_q.last_off;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(hit_cfg || hit_page || hit_stat);

	////////////////////////////////////////////////////////////////
	// off-chip sequence: latch strobe high then low for the programmed width on multiplexed pins, one setup cycle on separate pins,
	// a fixed strobe long enough for read data to clear the pin synchroniser,
	// one hold cycle with the pins still owned, then the answer as they free
	// next state
	always_comb begin
		s_d       = s_q;
		s_d.ack   = 1'b0;
		// two-stage synchroniser on the shared data pins
		s_d.sync1 = ad_i;
		s_d.sync2 = s_q.sync1;

		if (apb_setup) begin
			s_d.prdata = rd_mux;
		end
		if (apb_wr && hit_cfg) begin
			s_d.cfg = pwdata[`EMI_CFG_BUS_BIT:0];
		end
		if (apb_wr && hit_page) begin
			s_d.page = pwdata[7:0];
		end

		unique case (s_q.state)
			EMI_IDLE: begin
				if (accept) begin
					s_d.we       = cpu_we;
					s_d.wdata    = cpu_wdata;
					s_d.last_off = go_off;
					s_d.hi_o     = eff_addr[15:8];
					s_d.hi_oe    = go_off && drive_hi;
					if (!go_off) begin
						s_d.state = EMI_ONCHIP;
					end else if (!bus_sep) begin
						// first phase: strobe high, low address out
						s_d.state = EMI_ALE_HI;
						s_d.cnt   = ale_w;
						// held so a config write mid-access keeps high and low equal
						s_d.alw   = ale_w;
						s_d.own   = 1'b1;
						s_d.ale   = 1'b1;
						s_d.ad_o  = eff_addr[7:0];
						s_d.ad_oe = 1'b1;
						s_d.lo_oe = 1'b0;
					end else begin
						// separate pins: one address setup cycle, no strobe
						s_d.state = EMI_ALE_LO;
						s_d.cnt   = 2'h0;
						s_d.own   = 1'b1;
						s_d.lo_o  = eff_addr[7:0];
						s_d.lo_oe = 1'b1;
						s_d.ad_oe = 1'b0;
					end
				end
			end
			EMI_ONCHIP: begin
				s_d.state = EMI_IDLE;
				s_d.ack   = 1'b1;
				if (!s_q.we) begin
					s_d.rdata = ram_rdata;
				end
			end
			EMI_ALE_HI: begin
				if (s_q.cnt == 2'h0) begin
					// falling strobe freezes the outside latch
					s_d.state = EMI_ALE_LO;
					s_d.cnt   = s_q.alw;
					s_d.ale   = 1'b0;
				end else begin
					s_d.cnt = s_q.cnt - 2'h1;
				end
			end
			EMI_ALE_LO: begin
				if (s_q.cnt == 2'h0) begin
					// data replaces address on the same edge that the strobe asserts
					s_d.state = EMI_STROBE;
					s_d.cnt   = `EMI_STRB_CNT;
					s_d.ad_o  = s_q.wdata;
					s_d.ad_oe = s_q.we;
					s_d.rd_n  = s_q.we;
					s_d.wr_n  = !s_q.we;
				end else begin
					s_d.cnt = s_q.cnt - 2'h1;
				end
			end
			EMI_STROBE: begin
				if (s_q.cnt == 2'h0) begin
					s_d.state = EMI_HOLD;
					s_d.rd_n  = 1'b1;
					s_d.wr_n  = 1'b1;
					if (!s_q.we) begin
						s_d.rdata = s_q.sync2;
					end
				end else begin
					s_d.cnt = s_q.cnt - 2'h1;
				end
			end
			EMI_HOLD: begin
				// hand pins back to the port latches
				s_d.state = EMI_IDLE;
				s_d.ack   = 1'b1;
				s_d.own   = 1'b0;
				s_d.ad_oe = 1'b0;
				s_d.lo_oe = 1'b0;
				s_d.hi_oe = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s_q       <= '0;
			s_q.state <= EMI_IDLE;
			s_q.cfg   <= `EMI_CFG_RST;
			s_q.page  <= `EMI_PAGE_RST;
			s_q.rd_n  <= 1'b1;
			s_q.wr_n  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// every output except pready and pslverr straight from a flop, none decoded after the register
	assign prdata     = s_q.prdata;
	assign cpu_ack    = s_q.ack;
	assign cpu_rdata  = s_q.rdata;

	// shared pins and the separate address pins
	assign ad_o       = s_q.ad_o;
	assign ad_oe      = s_q.ad_oe;
	assign addr_lo_o  = s_q.lo_o;
	assign addr_lo_oe = s_q.lo_oe;
	assign addr_hi_o  = s_q.hi_o;
	assign addr_hi_oe = s_q.hi_oe;

	// strobes and pin ownership
	assign ale_o      = s_q.ale;
	assign rd_n_o     = s_q.rd_n;
	assign wr_n_o     = s_q.wr_n;
	assign bus_own_o  = s_q.own;

endmodule

/* verification/emi_props.sv */
`timescale 1ns/1ps
`include "emi_regs.svh"
module emi_props (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	// cpu side
	input wire logic        cpu_ack,
	// pins
	input wire logic        ad_oe,
	input wire logic        addr_lo_oe,
	input wire logic        ale_o,
	input wire logic        rd_n_o,
	input wire logic        wr_n_o,
	input wire logic        bus_own_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////
	property p_cfg_rd;
		psel && penable && paddr == `EMI_ADDR_CONFIG |-> prdata[31:5] == 27'h0;
	endproperty
	a_cfg_rd: assert property (p_cfg_rd) else $error("config upper bits set");
	property p_ale_w;
		$rose(ale_o) |-> ##[1:4] !ale_o;
	endproperty
	a_ale_w: assert property (p_ale_w) else $error("latch strobe too long");
	property p_ale_lo;
		ale_o |-> !addr_lo_oe;
	endproperty
	a_ale_lo: assert property (p_ale_lo) else $error("low address on own pins");
	property p_ale_own;
		ale_o |-> bus_own_o && ad_oe;
	endproperty
	a_ale_own: assert property (p_ale_own) else $error("strobe without address");
	property p_rd_oe;
		!rd_n_o |-> !ad_oe;
	endproperty
	a_rd_oe: assert property (p_rd_oe) else $error("pins driven during read");
	property p_strb_own;
		!rd_n_o || !wr_n_o |-> bus_own_o;
	endproperty
	a_strb_own: assert property (p_strb_own) else $error("strobe without owning");
	property p_own_end;
		$fell(bus_own_o) |-> cpu_ack;
	endproperty
	a_own_end: assert property (p_own_end) else $error("pins freed early");
	// five cycles is the shortest separate-pin access, twelve the longest multiplexed
	property p_own_len;
		$rose(bus_own_o) |-> bus_own_o[*5] ##[1:8] !bus_own_o;
	endproperty
	a_own_len: assert property (p_own_len) else $error("ownership length");
	c_ale: cover property ($rose(ale_o));
	c_wr_sep: cover property (!wr_n_o && addr_lo_oe);
	c_ack: cover property (cpu_ack && !bus_own_o);
endmodule
bind emi_ctrl emi_props i_emi_props (.clk_sys, .rstn, .psel, .penable, .paddr, .prdata,
	.cpu_ack, .ad_oe, .addr_lo_oe, .ale_o, .rd_n_o, .wr_n_o, .bus_own_o);

/* verification/emi_sram_model.sv */
`timescale 1ns/1ps
module emi_sram_model #(
	parameter logic [7:0] PARK_HI = 8'hFF
) (
	// clock
	input  wire logic       clk_sys,
	// pins from the interface
	input  wire logic [7:0] ad_o,
	input  wire logic       ad_oe,
	input  wire logic       ale_o,
	input  wire logic [7:0] addr_lo_o,
	input  wire logic       addr_lo_oe,
	input  wire logic [7:0] addr_hi_o,
	input  wire logic       addr_hi_oe,
	input  wire logic       rd_n_o,
	input  wire logic       wr_n_o,
	// shared pins back
	output logic      [7:0] ad_i
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lat_q;
	logic [7:0]  last_q;
	logic [15:0] a;
	////////////////////////////////////////////////////////////////
	always_latch if (ale_o) lat_q <= ad_o;
	// undriven upper byte shows the parked port level
	assign a = {addr_hi_oe ? addr_hi_o : PARK_HI, addr_lo_oe ? addr_lo_o : lat_q};
	// released bus shows the inverse of its last level, never a stale match
	assign ad_i = ad_oe ? ad_o : (!rd_n_o ? mem[a] : ~last_q);
	always_ff @(posedge clk_sys) begin
		last_q <= ad_i;
		if (!wr_n_o && ad_oe) mem[a] <= ad_o;
	end
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
`include "emi_regs.svh"
module testbench;
	logic        clk_sys = 1'b0;
	logic        rstn, psel, penable, pwrite, pready, pslverr, e;
	logic        cpu_req, cpu_we, cpu_is8, cpu_ack;
	logic        ad_oe, addr_lo_oe, addr_hi_oe, ale_o, rd_n_o, wr_n_o, bus_own_o;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] cpu_dptr;
	logic [7:0]  indirect_pointer_reg, cpu_wdata, cpu_rdata, ad_i, ad_o, addr_lo_o, addr_hi_o;
	logic [2:0]  w;
	int          n, k, fails, compares, owns;
	////////////////////////////////////////////////////////////////
	emi_ctrl i_emi_ctrl (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .cpu_req, .cpu_we, .cpu_is8, .cpu_dptr,
		.indirect_pointer_reg, .cpu_wdata, .cpu_ack, .cpu_rdata, .ad_i, .ad_o, .ad_oe,
		.addr_lo_o, .addr_lo_oe, .addr_hi_o, .addr_hi_oe, .ale_o, .rd_n_o, .wr_n_o,
		.bus_own_o);
	emi_sram_model i_emi_sram_model (.clk_sys, .ad_o, .ad_oe, .ale_o, .addr_lo_o,
		.addr_lo_oe, .addr_hi_o, .addr_hi_oe, .rd_n_o, .wr_n_o, .ad_i);
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (bus_own_o === 1'b1) owns <= owns + 1;
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int m = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			m++;
		end while (pready !== 1'b1 && m < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin fails++; end_of_test(); end
	endtask
	task automatic cfg(input logic [7:0] c);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, `EMI_ADDR_CONFIG, {24'h0, c}, rd, err);
	endtask
	// request held until the acknowledge is seen, so it is never taken twice
	task automatic mv(input logic wr, input logic s8, input logic [15:0] a,
		input logic [7:0] d, output int m);
		m = 0;
		@(posedge clk_sys);
		cpu_req <= 1'b1;
		cpu_we <= wr;
		cpu_is8 <= s8;
		cpu_dptr <= a;
		indirect_pointer_reg <= a[7:0];
		cpu_wdata <= d;
		do begin
			@(posedge clk_sys);
			m++;
		end while (cpu_ack !== 1'b1 && m < 40);
		cpu_req <= 1'b0;
		if (cpu_ack !== 1'b1) begin fails++; end_of_test(); end
	endtask
	task automatic ext(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
		input int t);
		int m;
		cfg(c);
		mv(1'b1, 1'b0, a, d, m);
		chk(m, t);
		chk(i_emi_sram_model.mem[a], d);
		mv(1'b0, 1'b0, a, 8'h00, m);
		chk(cpu_rdata, d);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, cpu_req, cpu_we, cpu_is8} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		cpu_dptr = 16'h0000;
		indirect_pointer_reg = 8'h00;
		cpu_wdata = 8'h00;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		apb(1'b0, `EMI_ADDR_CONFIG, 32'h0, r, e);
		chk(r, 32'h03);
		apb(1'b0, `EMI_ADDR_PAGE, 32'h0, r, e);
		chk(r, 32'h00);
		apb(1'b0, 12'h004, 32'h0, r, e);
		chk(e, 1'b1);
		apb(1'b1, `EMI_ADDR_CONFIG, 32'hFF, r, e);
		apb(1'b0, `EMI_ADDR_CONFIG, 32'h0, r, e);
		chk(r, 32'h1F);
		cfg(8'h03);
		k = owns;
		mv(1'b1, 1'b0, 16'h1005, 8'hAA, n);
		chk(n, 3);
		mv(1'b0, 1'b0, 16'h0005, 8'h00, n);
		chk(cpu_rdata, 8'hAA);
		chk(owns, k);
		for (w = 3'h0; w < 3'h4; w++) begin
			ext({6'h03, w[1:0]}, 16'h0010 + w, 8'h5A + w, 2 * w + 8);
			ext({6'h07, w[1:0]}, 16'h2340 + w, 8'hC0 + w, 7);
		end
		apb(1'b1, `EMI_ADDR_PAGE, 32'h20, r, e);
		cfg(8'h07);
		mv(1'b1, 1'b1, 16'h0034, 8'h77, n);
		chk(i_emi_sram_model.mem[16'hFF34], 8'h77);
		k = owns;
		mv(1'b1, 1'b0, 16'h0800, 8'h11, n);
		chk(owns, k);
		apb(1'b0, `EMI_ADDR_STATUS, 32'h0, r, e);
		chk(r, 32'h0);
		mv(1'b1, 1'b0, 16'h1800, 8'h22, n);
		chk(i_emi_sram_model.mem[16'h1800], 8'h22);
		cfg(8'h0B);
		mv(1'b1, 1'b1, 16'h0034, 8'h66, n);
		chk(i_emi_sram_model.mem[16'h2034], 8'h66);
		apb(1'b0, `EMI_ADDR_STATUS, 32'h0, r, e);
		chk(r, 32'h2);
		// second reset in mid-run puts the registers back to their defaults
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		apb(1'b0, `EMI_ADDR_CONFIG, 32'h0, r, e);
		chk(r, 32'h03);
		apb(1'b0, `EMI_ADDR_PAGE, 32'h0, r, e);
		chk(r, 32'h00);
		end_of_test();
	end
endmodule
